// >>> hdl/i2c_slave_params.svh
/*
 * Timing and encoding constants for the two-wire slave receive engine.
 * Assumes it is included by bare name from the design.
 */
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH
`define MODE_7BIT 2'h0
`define MODE_10BIT 2'h1
`define MODE_7BIT_SP 2'h2
`define MODE_10BIT_SP 2'h3
`define TEN_BIT_PREFIX 5'h1E
`define ADDR_RESET 8'h00
`define BITS_PER_BYTE 4'h8
`endif

// >>> hdl/i2c_slave_pkg.sv
/*
 * Types shared by the two-wire slave receive engine.
 * Assumes nothing beyond the constants header.
 */
package i2c_slave_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_HOLD8,
		ST_ACK,
		ST_WAIT_ADDR
	} slave_state_t;
	typedef enum logic [1:0] {
		PH_HIGH,
		PH_LOW,
		PH_DATA
	} addr_phase_t;
endpackage

// >>> hdl/i2c_slave_rx.sv
/*
 * Slave receive engine for a two-wire serial bus: start and stop
 * detection, 7-bit and 10-bit address match, acknowledge generation,
 * software hold points, clock stretching and a two-entry receive buffer.
 * Assumes the bus lines arrive asynchronously as open-drain levels and
 * that software drives the control inputs and pulse inputs from clk_sys_i.
 */
`include "i2c_slave_params.svh"

// Contract
// - Ninth pulse carries receiver acknowledge.
// - Transmitter releases data line during acknowledge.
// - Capture far party acknowledge into status.
// - Both holds set: drive software acknowledge bit.
// - Both holds clear: hardware acknowledges.
// - No acknowledge when full or overflowed; code still acknowledges with overwrite enabled, and with both holds set drives the software bit.
// - Acknowledge-time bit after eighth fall, holds only.
// - Mode field picks addressing and interrupt style.
// - Interrupt modes flag start, restart, stop.
// - First byte compared; match loads, interrupts.
// - 7-bit match ignores least significant bit.
// - 10-bit high byte matches 11110 A9 A8 0.
// - After high byte: update flag, stretch clock.
// - After low byte: interrupt, update, stretch.
// - 10-bit read needs prior full write match.
// - Write match clears read bit, acknowledges.
// - Interrupt per data byte until cleared.
// - Stretch after each byte until release.
// - Buffer read clears buffer-full flag.
// - Stop sets stop bit, bus idle.
// - Hold: eighth fall interrupts and stretches.
// - Hold: ninth fall interrupts unless not-acknowledged.
// - Start and stop from data edge, clock high.
// - Repeated start resets slave like start.
// - Start/stop enables add interrupts where absent.
module i2c_slave_rx (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic serial_clock_line_i,
	input wire logic serial_data_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_o,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_o,
	input wire logic [1:0] mode_select_field_i,
	input wire logic address_hold_enable_i,
	input wire logic data_hold_enable_i,
	input wire logic clock_stretch_enable_i,
	input wire logic buffer_overwrite_enable_i,
	input wire logic start_interrupt_enable_i,
	input wire logic stop_interrupt_enable_i,
	input wire logic ack_data_bit_i,
	input wire logic clock_release_set_i,
	input wire logic address_write_i,
	input wire logic [7:0] address_data_i,
	input wire logic interrupt_clear_i,
	input wire logic overflow_clear_i,
	input wire logic rx_ready_i,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic [7:0] slave_address_register_o,
	output logic serial_interrupt_flag_o,
	output logic buffer_full_flag_o,
	output logic receive_overflow_flag_o,
	output logic ack_status_bit_o,
	output logic ack_time_flag_o,
	output logic update_address_flag_o,
	output logic clock_release_bit_o,
	output logic read_write_bit_o,
	output logic start_seen_o,
	output logic stop_seen_o,
	output logic addressed_o
);
	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic scl_prev_ff;
	logic sda_prev_ff;
	wire logic scl_s = scl_sync_ff[1];
	wire logic sda_s = sda_sync_ff[1];
	wire logic scl_rise = scl_s & ~scl_prev_ff;
	wire logic scl_fall = ~scl_s & scl_prev_ff;
	wire logic start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
	wire logic stop_det = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

	i2c_slave_pkg::slave_state_t state_ff;
	i2c_slave_pkg::addr_phase_t phase_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] addr_ff;
	logic [7:0] buf_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] count_ff;
	logic ack_drive_ff;
	logic nack_sent_ff;
	logic prior_match_ff;
	logic stretch_ff;
	logic low_clock_ff;
	logic set_int;

	wire logic ten_bit = mode_select_field_i[0];
	// Upper mode bit selects start/stop interrupt modes.
	wire logic sp_mode = mode_select_field_i[1];
	wire logic holds_both = address_hold_enable_i & data_hold_enable_i;
	wire logic hold_any = address_hold_enable_i | data_hold_enable_i;
	wire logic is_addr = (phase_ff != i2c_slave_pkg::PH_DATA);
	wire logic hold_this = is_addr ? address_hold_enable_i
		: data_hold_enable_i;
	wire logic [7:0] byte_in = shift_ff;

	// 7-bit compare drops the direction bit.
	wire logic match7 = (byte_in[7:1] == addr_ff[7:1]);
	// High byte pattern from address bits 2 and 1.
	wire logic match_hi = (byte_in[7:3] == `TEN_BIT_PREFIX) &
		(byte_in[2:1] == addr_ff[2:1]);
	// Low byte compared on all eight bits.
	wire logic match_lo = (byte_in == addr_ff);
	wire logic addr_match = !ten_bit ? match7
		: (phase_ff == i2c_slave_pkg::PH_HIGH) ? match_hi : match_lo;
	// A read high byte only counts after a full write match.
	wire logic read_ok = !ten_bit | !byte_in[0] | prior_match_ff
		| (phase_ff != i2c_slave_pkg::PH_HIGH);
	wire logic accept = !is_addr | (addr_match & read_ok);
	// Refuse when full or overflowed unless overwrite allowed.
	wire logic overflowing = (buffer_full_flag_o | receive_overflow_flag_o)
		& !buffer_overwrite_enable_i;
	wire logic lo_phase = ten_bit & (phase_ff == i2c_slave_pkg::PH_LOW);
	wire logic ack_value = holds_both ? ~ack_data_bit_i : ~overflowing;
	wire logic buf_full = (count_ff == 2'h2);

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], serial_clock_line_i};
			sda_sync_ff <= {sda_sync_ff[0], serial_data_line_i};
			scl_prev_ff <= scl_s;
			sda_prev_ff <= sda_s;
		end
	end

	// Slave sequencing: shift, hold points, acknowledge slot.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_ff <= i2c_slave_pkg::ST_IDLE;
			phase_ff <= i2c_slave_pkg::PH_HIGH;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			ack_drive_ff <= 1'b0;
			nack_sent_ff <= 1'b0;
			addressed_o <= 1'b0;
			ack_time_flag_o <= 1'b0;
			read_write_bit_o <= 1'b0;
			stretch_ff <= 1'b0;
		end else if (start_det) begin
			// Repeated start restarts the address phase.
			state_ff <= i2c_slave_pkg::ST_SHIFT;
			phase_ff <= i2c_slave_pkg::PH_HIGH;
			bit_cnt_ff <= 4'h0;
			ack_drive_ff <= 1'b0;
			addressed_o <= 1'b0;
			ack_time_flag_o <= 1'b0;
			stretch_ff <= 1'b0;
		end else if (stop_det) begin
			// Stop returns the slave to idle.
			state_ff <= i2c_slave_pkg::ST_IDLE;
			ack_drive_ff <= 1'b0;
			addressed_o <= 1'b0;
			ack_time_flag_o <= 1'b0;
			stretch_ff <= 1'b0;
		end else begin
			if (clock_release_set_i)
				stretch_ff <= 1'b0;
			unique case (state_ff)
			i2c_slave_pkg::ST_IDLE: begin
			end
			i2c_slave_pkg::ST_SHIFT: begin
				if (scl_rise) begin
					shift_ff <= {shift_ff[6:0], sda_s};
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end else if (scl_fall && bit_cnt_ff == `BITS_PER_BYTE) begin
					bit_cnt_ff <= 4'h0;
					if (!accept && !lo_phase) begin
						state_ff <= i2c_slave_pkg::ST_IDLE;
					end else begin
						if (is_addr && !lo_phase)
							read_write_bit_o <= byte_in[0];
						// Acknowledge time marked in hold modes.
						ack_time_flag_o <= hold_any;
						// Hold point stretches after the eighth fall.
						if (hold_this && (accept || !lo_phase)) begin
							stretch_ff <= 1'b1;
							state_ff <= i2c_slave_pkg::ST_HOLD8;
						end else begin
							state_ff <= i2c_slave_pkg::ST_ACK;
							// Receiver pulls data low on ninth pulse.
							ack_drive_ff <= accept & ack_value;
						end
					end
				end
			end
			i2c_slave_pkg::ST_HOLD8: begin
				// Level settles while the clock is held, never as it rises.
				ack_drive_ff <= ack_value;
				if (!stretch_ff)
					state_ff <= i2c_slave_pkg::ST_ACK;
			end
			i2c_slave_pkg::ST_ACK: begin
				if (scl_fall) begin
					// Release data once the ninth pulse ends.
					ack_drive_ff <= 1'b0;
					ack_time_flag_o <= 1'b0;
					nack_sent_ff <= !ack_drive_ff;
					if (!ack_drive_ff && !lo_phase) begin
						state_ff <= i2c_slave_pkg::ST_IDLE;
					end else if (is_addr && ten_bit && !read_write_bit_o) begin
						// Wait for the low or high address rewrite.
						state_ff <= i2c_slave_pkg::ST_WAIT_ADDR;
						stretch_ff <= 1'b1;
						phase_ff <= (phase_ff == i2c_slave_pkg::PH_HIGH)
							? i2c_slave_pkg::PH_LOW : i2c_slave_pkg::PH_DATA;
						addressed_o <= !lo_phase | ack_drive_ff;
					end else begin
						state_ff <= i2c_slave_pkg::ST_SHIFT;
						phase_ff <= i2c_slave_pkg::PH_DATA;
						addressed_o <= 1'b1;
						if (clock_stretch_enable_i)
							stretch_ff <= 1'b1;
					end
				end
			end
			i2c_slave_pkg::ST_WAIT_ADDR: begin
				if (address_write_i) begin
					stretch_ff <= 1'b0;
					state_ff <= addressed_o ? i2c_slave_pkg::ST_SHIFT
						: i2c_slave_pkg::ST_IDLE;
				end
			end
			default: state_ff <= i2c_slave_pkg::ST_IDLE;
			endcase
		end
	end

	// Prior full match kept until stop or any high byte other than a matching read.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i || stop_det) begin
			prior_match_ff <= 1'b0;
		end else if (state_ff == i2c_slave_pkg::ST_SHIFT && scl_fall
			&& bit_cnt_ff == `BITS_PER_BYTE && ten_bit) begin
			if (phase_ff == i2c_slave_pkg::PH_HIGH
				&& (!match_hi || !byte_in[0]))
				prior_match_ff <= 1'b0;
			else if (lo_phase && match_lo)
				prior_match_ff <= 1'b1;
		end
	end

	// Slave address register and update-address flag.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			addr_ff <= `ADDR_RESET;
			slave_address_register_o <= `ADDR_RESET;
			update_address_flag_o <= 1'b0;
		end else if (state_ff == i2c_slave_pkg::ST_ACK && scl_fall
			&& is_addr && ten_bit && !read_write_bit_o
			&& (ack_drive_ff || lo_phase)) begin
			// Update flag set after high and low bytes.
			update_address_flag_o <= 1'b1;
		end else if (address_write_i) begin
			addr_ff <= address_data_i;
			slave_address_register_o <= address_data_i;
			update_address_flag_o <= 1'b0;
		end
	end

	// Acknowledge seen on the ninth rising edge.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			ack_status_bit_o <= 1'b0;
		else if (state_ff == i2c_slave_pkg::ST_ACK && scl_rise)
			ack_status_bit_o <= sda_s;
	end

	// Interrupt sources; a new event wins over a software clear.
	always_comb begin
		set_int = 1'b0;
		// Separate enables add them in plain modes.
		if (start_det && (sp_mode || start_interrupt_enable_i))
			set_int = 1'b1;
		if (stop_det && (sp_mode || stop_interrupt_enable_i))
			set_int = 1'b1;
		if (state_ff == i2c_slave_pkg::ST_SHIFT && scl_fall
			&& bit_cnt_ff == `BITS_PER_BYTE && hold_this
			&& (accept || !lo_phase) && !start_det && !stop_det)
			set_int = 1'b1;
		// Low address byte interrupts even on mismatch.
		if (state_ff == i2c_slave_pkg::ST_ACK && scl_fall
			&& (ack_drive_ff || lo_phase) && !start_det && !stop_det)
			set_int = 1'b1;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			serial_interrupt_flag_o <= 1'b0;
		else if (set_int)
			serial_interrupt_flag_o <= 1'b1;
		else if (interrupt_clear_i)
			serial_interrupt_flag_o <= 1'b0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			start_seen_o <= 1'b0;
			stop_seen_o <= 1'b0;
		end else if (start_det) begin
			start_seen_o <= 1'b1;
			stop_seen_o <= 1'b0;
		end else if (stop_det) begin
			start_seen_o <= 1'b0;
			stop_seen_o <= 1'b1;
		end
	end

	// Two-entry receive buffer; a byte arriving while both entries are full is dropped.
	wire logic push = state_ff == i2c_slave_pkg::ST_SHIFT && scl_fall
		&& bit_cnt_ff == `BITS_PER_BYTE && accept && !overflowing
		&& !(lo_phase && !match_lo) && !buf_full && !start_det;
	wire logic pop = rx_valid_o & rx_ready_i;
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff <= 2'h0;
			buf_ff[0] <= 8'h00;
			buf_ff[1] <= 8'h00;
		end else begin
			if (push) begin
				buf_ff[wr_ptr_ff] <= byte_in;
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
			buffer_full_flag_o <= 1'b0;
		end else begin
			rx_valid_o <= (count_ff + {1'b0, push} - {1'b0, pop}) != 2'h0;
			rx_data_o <= (pop || count_ff == 2'h0)
				? ((count_ff == 2'h2 || (count_ff == 2'h1 && !pop))
					? buf_ff[~rd_ptr_ff] : byte_in)
				: buf_ff[rd_ptr_ff];
			// Reading the buffer clears buffer full.
			if (push)
				buffer_full_flag_o <= 1'b1;
			else if (pop)
				buffer_full_flag_o <= 1'b0;
		end
	end

	// Overflow when a byte lands on a full buffer.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i)
			receive_overflow_flag_o <= 1'b0;
		else if (state_ff == i2c_slave_pkg::ST_SHIFT && scl_fall
			&& bit_cnt_ff == `BITS_PER_BYTE && accept
			&& (buffer_full_flag_o || buf_full))
			receive_overflow_flag_o <= 1'b1;
		else if (overflow_clear_i)
			receive_overflow_flag_o <= 1'b0;
	end

	// Open-drain drivers: output value is always low, enable pulls.
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			low_clock_ff <= 1'b0;
			serial_clock_line_o <= 1'b0;
			serial_clock_line_oe_o <= 1'b0;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe_o <= 1'b0;
			clock_release_bit_o <= 1'b1;
		end else begin
			low_clock_ff <= stretch_ff & ~scl_s;
			serial_clock_line_oe_o <= stretch_ff & (~scl_s | low_clock_ff);
			serial_data_line_oe_o <= ack_drive_ff;
			clock_release_bit_o <= ~stretch_ff;
		end
	end
endmodule // i2c_slave_rx

// >>> verif/i2c_master_model.sv
/*
 * Bus master model driving the clock and data lines open-drain.
 * Assumes the bench resolves both lines with pull-ups.
 */
module i2c_master_model (
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_oe_o,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// A stretching slave is waited out, but never forever.
	task automatic rise();
		scl_oe_o <= 1'b0;
		tick(1);
		repeat (3000) if (scl_i !== 1'b1) tick(1);
		tick(3);
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_oe_o <= !b;
		tick(3);
		rise();
		s = sda_i;
		scl_oe_o <= 1'b1;
		tick(1);
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic start();
		sda_oe_o <= 1'b0;
		tick(4);
		rise();
		sda_oe_o <= 1'b1;
		tick(6);
		scl_oe_o <= 1'b1;
		tick(2);
	endtask
	task automatic stop();
		sda_oe_o <= 1'b1;
		tick(4);
		rise();
		sda_oe_o <= 1'b0;
		tick(8);
	endtask
endmodule // i2c_master_model

// >>> verif/i2c_slave_rx_checker.sv
/*
 * Port-level assertions for the two-wire slave receive engine.
 * Assumes it is bound into every instance of i2c_slave_rx.
 */
module i2c_slave_rx_checker (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic serial_clock_line_oe_o,
	input wire logic serial_data_line_oe_o,
	input wire logic address_hold_enable_i,
	input wire logic data_hold_enable_i,
	input wire logic ack_data_bit_i,
	input wire logic clock_release_set_i,
	input wire logic address_write_i,
	input wire logic interrupt_clear_i,
	input wire logic overflow_clear_i,
	input wire logic serial_interrupt_flag_o,
	input wire logic receive_overflow_flag_o,
	input wire logic ack_time_flag_o,
	input wire logic update_address_flag_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	AST_SW_ACK: assert property (
		$rose(serial_data_line_oe_o) && address_hold_enable_i &&
		data_hold_enable_i |-> !ack_data_bit_i) else $error("ack vs soft bit");
	AST_NO_ACK_OVF: assert property (
		$rose(serial_data_line_oe_o) |-> !$past(receive_overflow_flag_o))
		else $error("ack while overflowed");
	AST_ACK_TIME_FLAG_HOLD: assert property (
		$rose(ack_time_flag_o) |-> address_hold_enable_i || data_hold_enable_i)
		else $error("ack time flag without hold");
	AST_HOLD_STRETCH: assert property (
		$rose(ack_time_flag_o) |-> ##[0:3] serial_clock_line_oe_o)
		else $error("no stretch at hold point");
	AST_RELEASE: assert property (
		clock_release_set_i && !update_address_flag_o
		|-> ##[1:4] !serial_clock_line_oe_o) else $error("clock not freed");
	AST_UA_CLEAR: assert property (
		address_write_i |-> ##[1:2] !update_address_flag_o)
		else $error("update flag kept after write");
	AST_IRQ_STICKY: assert property (
		serial_interrupt_flag_o && !interrupt_clear_i |=> serial_interrupt_flag_o)
		else $error("interrupt flag dropped");
	AST_OVF_STICKY: assert property (
		receive_overflow_flag_o && !overflow_clear_i |=> receive_overflow_flag_o)
		else $error("overflow flag dropped");
endmodule // i2c_slave_rx_checker

bind i2c_slave_rx i2c_slave_rx_checker checker_inst (
	.clk_sys_i,
	.reset_n_i,
	.serial_clock_line_oe_o,
	.serial_data_line_oe_o,
	.address_hold_enable_i,
	.data_hold_enable_i,
	.ack_data_bit_i,
	.clock_release_set_i,
	.address_write_i,
	.interrupt_clear_i,
	.overflow_clear_i,
	.serial_interrupt_flag_o,
	.receive_overflow_flag_o,
	.ack_time_flag_o,
	.update_address_flag_o
);

// >>> verif/i2c_slave_rx_tb.sv
/*
 * Self-checking bench for the two-wire slave receive engine.
 * Assumes the master model and the bound checker are compiled first.
 */
module i2c_slave_rx_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0, reset_n_i = 1'b0, m_scl_oe, m_sda_oe;
	logic serial_clock_line_i, serial_data_line_i, serial_clock_line_o;
	logic serial_clock_line_oe_o, serial_data_line_o, serial_data_line_oe_o;
	logic [1:0] mode_select_field_i = 2'h0;
	logic address_hold_enable_i = 1'b0, data_hold_enable_i = 1'b0;
	logic clock_stretch_enable_i = 1'b0, buffer_overwrite_enable_i = 1'b0;
	logic start_interrupt_enable_i = 1'b0, stop_interrupt_enable_i = 1'b0;
	logic ack_data_bit_i = 1'b0, clock_release_set_i = 1'b0;
	logic address_write_i = 1'b0, interrupt_clear_i = 1'b0;
	logic overflow_clear_i = 1'b0, rx_ready_i = 1'b1, a;
	logic [7:0] address_data_i = 8'h00, rx_data_o, slave_address_register_o, d;
	logic rx_valid_o, serial_interrupt_flag_o, buffer_full_flag_o;
	logic receive_overflow_flag_o, ack_status_bit_o, ack_time_flag_o;
	logic update_address_flag_o, clock_release_bit_o, read_write_bit_o;
	logic start_seen_o, stop_seen_o, addressed_o;
	logic [7:0] exp_q[$];
	int miscompares = 0, checks = 0, cyc = 0, seed = 32'h50551245;
	assign serial_clock_line_i = !(m_scl_oe | serial_clock_line_oe_o);
	assign serial_data_line_i = !(m_sda_oe | serial_data_line_oe_o);
	i2c_slave_rx dut (.*);
	i2c_master_model m (.clk_i(clk_sys_i), .scl_i(serial_clock_line_i),
		.sda_i(serial_data_line_i), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
	always #2 clk_sys_i = ~clk_sys_i;
	task automatic chk8(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic sw_addr(input logic [7:0] v);
		address_data_i <= v;
		address_write_i <= 1'b1;
		tick(1);
		address_write_i <= 1'b0;
	endtask
	task automatic clr_irq();
		interrupt_clear_i <= 1'b1;
		tick(1);
		interrupt_clear_i <= 1'b0;
		tick(1);
	endtask
	task automatic wait_hi(ref logic s);
		repeat (900) if (s !== 1'b1) tick(1);
	endtask
	task automatic xfer(input logic [7:0] b, input logic e);
		logic k;
		if (e) exp_q.push_back(b);
		m.send_byte(b, k);
		chk1("ack", e, k);
		tick(4);
	endtask
	// Software decides the acknowledge at the hold point, then frees clock.
	task automatic hold_point(input logic nack);
		wait_hi(serial_interrupt_flag_o);
		tick(3);
		chk1("ack_time", 1'b1, ack_time_flag_o);
		chk1("stretch", 1'b1, serial_clock_line_oe_o);
		chk1("release", 1'b0, clock_release_bit_o);
		ack_data_bit_i <= nack;
		clr_irq();
		clock_release_set_i <= 1'b1;
		tick(1);
		clock_release_set_i <= 1'b0;
	endtask
	always @(posedge clk_sys_i) begin
		if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
			chk8("rx_data", exp_q.size() ? exp_q.pop_front() : 8'hXX, rx_data_o);
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		tick(5);
		reset_n_i <= 1'b1;
		tick(4);
		sw_addr(8'hA4);
		m.start();
		chk1("start", 1'b1, start_seen_o);
		chk8("addr", 8'hA4, slave_address_register_o);
		xfer(8'hA4, 1'b1);
		chk1("rw", 1'b0, read_write_bit_o);
		chk1("addressed", 1'b1, addressed_o);
		chk1("ack_status_bit", 1'b0, ack_status_bit_o);
		for (int i = 0; i < 4; i++) begin
			clr_irq();
			d = 8'($random(seed));
			xfer(d, 1'b1);
			chk1("irq", 1'b1, serial_interrupt_flag_o);
		end
		m.stop();
		chk1("stop", 1'b1, stop_seen_o);
		start_interrupt_enable_i <= 1'b1;
		clr_irq();
		m.start();
		chk1("irq", 1'b1, serial_interrupt_flag_o);
		start_interrupt_enable_i <= 1'b0;
		clr_irq();
		xfer(8'h5A, 1'b0);
		chk1("irq", 1'b0, serial_interrupt_flag_o);
		m.stop();
		rx_ready_i <= 1'b0;
		m.start();
		for (int i = 0; i < 4; i++) begin
			a = !(buffer_full_flag_o | receive_overflow_flag_o);
			xfer(i ? 8'(i * 17) : 8'hA4, a);
		end
		chk1("ovf", 1'b1, receive_overflow_flag_o);
		m.stop();
		rx_ready_i <= 1'b1;
		tick(8);
		chk1("full", 1'b0, buffer_full_flag_o);
		overflow_clear_i <= 1'b1;
		tick(1);
		overflow_clear_i <= 1'b0;
		mode_select_field_i <= 2'h3;
		sw_addr(8'hF6);
		clr_irq();
		m.start();
		chk1("irq", 1'b1, serial_interrupt_flag_o);
		clr_irq();
		fork
			begin
				xfer(8'hF6, 1'b1);
				xfer(8'h5D, 1'b1);
			end
			begin
				wait_hi(serial_clock_line_oe_o);
				chk1("ua", 1'b1, update_address_flag_o);
				sw_addr(8'h5D);
				tick(20);
				wait_hi(serial_clock_line_oe_o);
				chk1("ua", 1'b1, update_address_flag_o);
				sw_addr(8'hF6);
			end
		join
		tick(3);
		chk1("ua", 1'b0, update_address_flag_o);
		xfer(8'h3C, 1'b1);
		m.start();
		xfer(8'hF7, 1'b1);
		chk1("rw", 1'b1, read_write_bit_o);
		m.stop();
		mode_select_field_i <= 2'h0;
		address_hold_enable_i <= 1'b1;
		data_hold_enable_i <= 1'b1;
		sw_addr(8'hA4);
		clr_irq();
		m.start();
		fork
			xfer(8'hA4, 1'b1);
			hold_point(1'b0);
		join
		chk1("irq", 1'b1, serial_interrupt_flag_o);
		clr_irq();
		exp_q.push_back(8'h96);
		fork
			m.send_byte(8'h96, a);
			hold_point(1'b1);
		join
		chk1("nack", 1'b0, a);
		chk1("ack_status_bit", 1'b1, ack_status_bit_o);
		tick(6);
		chk1("irq", 1'b0, serial_interrupt_flag_o);
		m.stop();
		tick(10);
		chk8("left", 8'h00, 8'(exp_q.size()));
		end_sim();
	end
endmodule // i2c_slave_rx_tb
